//--- verilog/sipa_isp_port.sv
// Purpose: Slave side of the serial programming port of the code memory.
// Assumes: Serial pins and reset pin are asynchronous to i_clock.
// Notes:   Serial clock is sampled and its edges found on i_clock.
`timescale 1ns/1ns
module sipa_isp_port
   import sipa_pkg::*;
#(
   parameter int POR_COUNT = POR_CYCLES
) (
   input  wire logic                i_clock,        // System clock
   input  wire logic                i_arst_n,       // Async reset, active low
   input  wire logic                i_rst_pin_n,    // Device reset pin, low = reset
   input  wire logic                i_sck,          // Serial clock pin
   input  wire logic                i_ss_n,         // Slave select pin, active low
   input  wire logic                i_mosi,         // Serial data in
   output logic                     o_miso,         // Serial data out
   output logic                     o_miso_oe,      // Drive enable for data out
   output logic                     o_io_release,   // General I/O pins tristated
   output logic                     o_por_done,     // Power-on reset complete
   output logic                     o_in_system_programming_mode, // Mode flag
   output logic [PAGE_W-1:0]        o_rd_page,      // Read page address
   output logic [OFFSET_W-1:0]      o_rd_offset,    // Read byte address
   input  wire logic [7:0]          i_rd_data,      // Memory byte at read address
   output logic                     o_wr_valid,     // Stream word valid
   input  wire logic                i_wr_ready,     // Stream word taken
   output logic [STREAM_W-1:0]      o_wr_word,      // Opcode, page, offset, data
   output logic                     o_cmd_done,     // Command completed pulse
   output logic [7:0]               o_cmd_opcode,   // Opcode of last command
   output logic [PAGE_W-1:0]        o_cmd_page,     // Page of last command
   output logic                     o_reload_error, // Position loaded twice
   output logic                     o_overrun       // Byte lost to stall
);

   // Synchronisers and edge history
   logic [1:0]        rst_sync_reg;
   logic [2:0]        sck_sync_reg;
   logic [2:0]        ss_sync_reg;
   logic [1:0]        mosi_sync_reg;
   logic              rst_q;
   logic              sck_rise;
   logic              sck_fall;
   logic              ss_fall;
   logic              ss_rise;
   logic              ss_q;
   logic              mosi_q;

   logic [POR_CNT_W-1:0] por_cnt_reg;
   logic              por_done_reg;
   logic              prog_mode_reg;
   sipa_state_t       state_reg;
   logic [2:0]        bit_cnt_reg;
   logic [2:0]        byte_idx_reg;
   logic [7:0]        rx_reg;
   logic [7:0]        tx_reg;
   logic [7:0]        opcode_reg;
   logic [7:0]        addr_hi_reg;
   logic [PAGE_W-1:0] page_reg;
   logic [OFFSET_W-1:0] offset_reg;
   logic [PAGE_BYTES-1:0] loaded_reg;
   logic              pend_valid_reg;
   logic [STREAM_W-1:0] pend_word_reg;
   logic              cmd_done_reg;
   logic [7:0]        cmd_opcode_reg;
   logic [PAGE_W-1:0] cmd_page_reg;
   logic              reload_err_reg;
   logic              overrun_reg;
   logic              byte_done;
   logic [7:0]        rx_byte;
   logic              in_data_byte;
   logic              buf_in_ready;

   // Pin synchronisers: first stage feeds only the second
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_sync_reg  <= 2'h0;
         sck_sync_reg  <= 3'h0;
         ss_sync_reg   <= 3'h7;
         mosi_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg  <= {rst_sync_reg[0], i_rst_pin_n};
         sck_sync_reg  <= {sck_sync_reg[1:0], i_sck};
         ss_sync_reg   <= {ss_sync_reg[1:0], i_ss_n};
         mosi_sync_reg <= {mosi_sync_reg[0], i_mosi};
      end
   end

   assign rst_q    = rst_sync_reg[1];
   assign ss_q     = ss_sync_reg[1];
   assign mosi_q   = mosi_sync_reg[1];
   // Serial clock edges found on the system clock
   assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
   assign sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
   assign ss_fall  = ~ss_sync_reg[1] & ss_sync_reg[2];
   assign ss_rise  = ss_sync_reg[1] & ~ss_sync_reg[2];

   // I/O released once synchronised reset low is seen
   assign o_io_release = ~rst_q | ~por_done_reg;

   // Power-on reset counter
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         por_cnt_reg  <= '0;
         por_done_reg <= 1'b0;
      end else if (!por_done_reg) begin
         por_cnt_reg  <= por_cnt_reg + 1'b1;
         por_done_reg <= (por_cnt_reg == POR_CNT_W'(POR_COUNT - 1));
      end
   end

   // Mode held only while reset pin is low
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         prog_mode_reg <= 1'b0;
      end else begin
         prog_mode_reg <= por_done_reg & ~rst_q;
      end
   end

   // Shift in on rising edge inside a frame
   assign byte_done    = sck_rise & ~ss_q & prog_mode_reg & (bit_cnt_reg == BIT_LAST);
   assign rx_byte      = {rx_reg[6:0], mosi_q};
   assign in_data_byte = byte_done & (state_reg == ST_DATA);

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rx_reg      <= 8'h00;
         bit_cnt_reg <= 3'h0;
      end else if (ss_q || !prog_mode_reg) begin
         bit_cnt_reg <= 3'h0;
      end else if (sck_rise) begin
         rx_reg      <= rx_byte;
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   // Shift out on falling edge; new byte loads from memory
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx_reg <= 8'h00;
      end else if (ss_fall) begin
         tx_reg <= 8'h00;
      end else if (sck_fall && !ss_q && prog_mode_reg) begin
         if (bit_cnt_reg == 3'h0 && state_reg == ST_DATA) begin
            tx_reg <= i_rd_data;
         end else begin
            tx_reg <= {tx_reg[6:0], 1'b0};
         end
      end
   end

   assign o_miso    = tx_reg[7];
   assign o_miso_oe = prog_mode_reg & ~ss_q;

   // Packet framing: preamble, header, data
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg    <= ST_IDLE;
         byte_idx_reg <= 3'h0;
      end else if (!prog_mode_reg || ss_q) begin
         state_reg    <= ST_IDLE;
         byte_idx_reg <= 3'h0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               state_reg    <= ST_PRE;
               byte_idx_reg <= 3'h0;
            end
            ST_PRE: begin
               if (byte_done) begin
                  byte_idx_reg <= byte_idx_reg + 3'h1;
                  if (byte_idx_reg == IDX_PRE0 && rx_byte != PREAMBLE_0) begin
                     state_reg <= ST_SKIP;
                  end else if (byte_idx_reg == IDX_PRE1) begin
                     state_reg <= (rx_byte == PREAMBLE_1) ? ST_HDR : ST_SKIP;
                  end
               end
            end
            ST_HDR: begin
               if (byte_done) begin
                  byte_idx_reg <= byte_idx_reg + 3'h1;
                  if (byte_idx_reg == IDX_ADDRLO) begin
                     state_reg <= ST_DATA;
                  end
               end
            end
            ST_DATA: state_reg <= ST_DATA;
            ST_SKIP: state_reg <= ST_SKIP;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Header capture, page fixed, offset sweep with wrap
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         opcode_reg  <= 8'h00;
         addr_hi_reg <= 8'h00;
         page_reg    <= '0;
         offset_reg  <= '0;
      end else if (byte_done && state_reg == ST_HDR) begin
         if (byte_idx_reg == IDX_OPCODE) begin
            opcode_reg <= rx_byte;
         end
         if (byte_idx_reg == IDX_ADDRHI) begin
            addr_hi_reg <= rx_byte;
         end
         if (byte_idx_reg == IDX_ADDRLO) begin
            page_reg   <= sipa_page_of({addr_hi_reg, rx_byte});
            offset_reg <= sipa_offset_of({addr_hi_reg, rx_byte});
         end
      end else if (in_data_byte) begin
         offset_reg <= offset_reg + 1'b1;
      end
   end

   assign o_rd_page   = page_reg;
   assign o_rd_offset = offset_reg;

   // Pending byte waits for room in the buffer; set wins over clear
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pend_valid_reg <= 1'b0;
         pend_word_reg  <= '0;
      end else if (in_data_byte) begin
         pend_valid_reg <= 1'b1;
         pend_word_reg  <= {opcode_reg, page_reg, offset_reg, rx_byte};
      end else if (buf_in_ready) begin
         pend_valid_reg <= 1'b0;
      end
   end

   // Loaded-position tracking and error flags
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         loaded_reg     <= '0;
         reload_err_reg <= 1'b0;
         overrun_reg    <= 1'b0;
      end else if (ss_fall) begin
         loaded_reg     <= '0;
         reload_err_reg <= 1'b0;
         overrun_reg    <= 1'b0;
      end else if (in_data_byte) begin
         loaded_reg[offset_reg] <= 1'b1;
         if (loaded_reg[offset_reg]) begin
            reload_err_reg <= 1'b1;
         end
         if (pend_valid_reg && !buf_in_ready) begin
            overrun_reg <= 1'b1;
         end
      end
   end

   // Command completes on select high
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cmd_done_reg   <= 1'b0;
         cmd_opcode_reg <= 8'h00;
         cmd_page_reg   <= '0;
      end else begin
         cmd_done_reg <= ss_rise & prog_mode_reg & (state_reg == ST_DATA);
         if (ss_rise && prog_mode_reg && state_reg == ST_DATA) begin
            cmd_opcode_reg <= opcode_reg;
            cmd_page_reg   <= page_reg;
         end
      end
   end

   assign o_por_done                   = por_done_reg;
   assign o_in_system_programming_mode = prog_mode_reg;
   assign o_cmd_done                   = cmd_done_reg;
   assign o_cmd_opcode                 = cmd_opcode_reg;
   assign o_cmd_page                   = cmd_page_reg;
   assign o_reload_error               = reload_err_reg;
   assign o_overrun                    = overrun_reg;

   // Write stream buffer
   sipa_pair_buf #(.WIDTH(STREAM_W)) u_buf (
      .i_clock     (i_clock),
      .i_arst_n    (i_arst_n),
      .i_in_valid  (pend_valid_reg),
      .o_in_ready  (buf_in_ready),
      .i_in_data   (pend_word_reg),
      .o_out_valid (o_wr_valid),
      .i_out_ready (i_wr_ready),
      .o_out_data  (o_wr_word)
   );

   // Checks
   sequence s_data_byte;
      in_data_byte;
   endsequence

   sequence s_hdr_last;
      byte_done && state_reg == ST_HDR && byte_idx_reg == IDX_ADDRLO;
   endsequence

   a_page_from_addr: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      s_hdr_last |=> page_reg == {$past(addr_hi_reg[2:0]), $past(rx_byte[7:5])}
                     && offset_reg == $past(rx_byte[4:0]))
      else $error("page or offset not decoded from address");
   a_page_held: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      state_reg == ST_DATA && $past(state_reg) == ST_DATA |-> $stable(page_reg))
      else $error("page changed inside a command");
   a_offset_step: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      s_data_byte |=> offset_reg == $past(offset_reg) + 5'h01)
      else $error("offset did not advance by one");
   a_offset_wrap: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      s_data_byte ##0 (offset_reg == 5'h1F) |=> offset_reg == 5'h00 && $stable(page_reg))
      else $error("offset did not wrap within page");
   a_reload_flag: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      s_data_byte ##0 loaded_reg[offset_reg] |=> o_reload_error)
      else $error("second load of a position not flagged");
   a_io_release: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      $fell(i_rst_pin_n) && o_por_done |-> ##[1:2] o_io_release)
      else $error("I/O not released in time after reset low");
   a_mode_reset: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      o_in_system_programming_mode |-> !$past(rst_q) && o_por_done)
      else $error("programming mode without reset low");
   a_idle_quiet: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      !prog_mode_reg |-> !o_miso_oe && state_reg == ST_IDLE)
      else $error("port active outside programming mode");
   a_bad_preamble: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      byte_done && state_reg == ST_PRE && byte_idx_reg == IDX_PRE0 && rx_byte != PREAMBLE_0
      |=> state_reg == ST_SKIP || state_reg == ST_IDLE)
      else $error("bad preamble accepted");
   a_done_on_select: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      o_cmd_done |-> $past(ss_rise) && ss_q)
      else $error("command done without select high");
   a_sample_rise: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      sck_rise && !ss_q && prog_mode_reg |=> rx_reg[0] == $past(mosi_q))
      else $error("data not sampled on rising edge");

endmodule : sipa_isp_port

//--- verilog/sipa_pkg.sv
// Purpose: Shared constants and types for the serial programming port.
// Assumes: 100 MHz system clock; pages of 32 bytes, 64 pages.
// Notes:   All timing figures are kept in their printed unit and converted.
package sipa_pkg;

   // System clock
   localparam int CLK_PERIOD_NS = 10;

   // Power-on reset time, printed in microseconds
   localparam int POR_TIME_US    = 100;
   localparam int POR_CYCLES     = (POR_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int POR_CNT_W      = 14;

   // Serial clock least period, printed in ns, and its cycle count
   localparam int SCK_MIN_NS     = 200;
   localparam int SCK_MIN_CYCLES = (SCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Address field layout
   localparam int ADDR_W         = 16;
   localparam int OFFSET_W       = 5;
   localparam int PAGE_W         = 6;
   localparam int OFFSET_LSB     = 0;
   localparam int PAGE_LSB       = OFFSET_LSB + OFFSET_W;
   localparam int PAGE_BYTES     = 32;

   // Packet preamble
   localparam logic [7:0] PREAMBLE_0 = 8'hAA;
   localparam logic [7:0] PREAMBLE_1 = 8'h55;

   // Byte positions within the packet header, and index of the last bit of a byte
   localparam logic [2:0] IDX_PRE0   = 3'h0;
   localparam logic [2:0] IDX_PRE1   = 3'h1;
   localparam logic [2:0] IDX_OPCODE = 3'h2;
   localparam logic [2:0] IDX_ADDRHI = 3'h3;
   localparam logic [2:0] IDX_ADDRLO = 3'h4;
   localparam logic [2:0] BIT_LAST   = 3'h7;

   // Word carried by the write stream: opcode, page, offset, data
   localparam int STREAM_W       = 8 + PAGE_W + OFFSET_W + 8;

   // Frame states
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_PRE  = 5'h02,
      ST_HDR  = 5'h04,
      ST_DATA = 5'h08,
      ST_SKIP = 5'h10
   } sipa_state_t;

   // Page number from the two address bytes
   function automatic logic [PAGE_W-1:0] sipa_page_of(input logic [ADDR_W-1:0] addr);
      sipa_page_of = addr[PAGE_LSB +: PAGE_W];
   endfunction : sipa_page_of

   // Byte offset from the two address bytes
   function automatic logic [OFFSET_W-1:0] sipa_offset_of(input logic [ADDR_W-1:0] addr);
      sipa_offset_of = addr[OFFSET_LSB +: OFFSET_W];
   endfunction : sipa_offset_of

endpackage : sipa_pkg

//--- verilog/sipa_pair_buf.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Single clock, asynchronous active-low reset.
// Notes:   Output data comes straight from the storage flip-flops.
`timescale 1ns/1ns
module sipa_pair_buf
   import sipa_pkg::*;
#(
   parameter int WIDTH = STREAM_W
) (
   input  wire logic             i_clock,     // System clock
   input  wire logic             i_arst_n,    // Async reset, active low
   input  wire logic             i_in_valid,  // Word offered
   output logic                  o_in_ready,  // Room for a word
   input  wire logic [WIDTH-1:0] i_in_data,   // Word in
   output logic                  o_out_valid, // Word available
   input  wire logic             i_out_ready, // Receiver takes word
   output logic      [WIDTH-1:0] o_out_data   // Word out
);

   logic [WIDTH-1:0] mem_reg [0:1];
   logic             wr_ptr_reg;
   logic             rd_ptr_reg;
   logic [1:0]       count_reg;
   logic             push;
   logic             pop;

   // Honest full and empty
   assign o_in_ready  = (count_reg != 2'h2);
   assign o_out_valid = (count_reg != 2'h0);
   assign o_out_data  = mem_reg[rd_ptr_reg];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   // Storage and pointers
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
            wr_ptr_reg          <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
      end
   end

   // Fill level
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count_reg <= 2'h0;
      end else if (push && !pop) begin
         count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
         count_reg <= count_reg - 2'h1;
      end
   end

endmodule : sipa_pair_buf

//--- testbench/sipa_prog_model.sv
// Purpose: Programmer model, mode 0 master of the serial programming port.
// Assumes: Serial clock period 160 ns; clock stands low between frames.
// Notes:   A released data line shows the inverse of its last value.
`timescale 1ns/1ns
module sipa_prog_model (
   output logic      o_sck,   // Serial clock
   output logic      o_ss_n,  // Slave select, active low
   output logic      o_mosi,  // Data to device
   output logic      o_rst_n, // Device reset pin
   input  wire logic i_miso   // Data from device
);
   localparam int HALF_NS = 80;

   // Idle levels at power-on
   initial begin
      o_sck   = 1'b0;
      o_ss_n  = 1'b1;
      o_mosi  = 1'b0;
      o_rst_n = 1'b1;
   end

   // One byte, MSB first, data set while clock low
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_mosi = tx[i];
         #HALF_NS;
         o_sck = 1'b1;
         rx[i] = i_miso;
         #HALF_NS;
         o_sck = 1'b0;
      end
   endtask : xfer

   // Whole packet framed by select
   task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
      logic [7:0] b;
      rx = {};
      #3;
      o_ss_n = 1'b0;
      #HALF_NS;
      foreach (tx[i]) begin
         xfer(tx[i], b);
         rx.push_back(b);
      end
      #HALF_NS;
      o_ss_n = 1'b1;
      o_mosi = ~o_mosi;
   endtask : frame

   // Entry from running mode
   task automatic enter();
      o_rst_n = 1'b0;
      o_ss_n  = 1'b1;
      #300;
   endtask : enter

   // Leaving programming mode
   task automatic leave();
      o_sck = 1'b0;
      #HALF_NS;
      o_ss_n = 1'b1;
      o_mosi = ~o_mosi;
      #HALF_NS;
      o_rst_n = 1'b1;
   endtask : leave
endmodule : sipa_prog_model

//--- testbench/sipa_isp_port_tb.sv
// Purpose: Self-checking bench of the serial programming port.
// Assumes: Shortened power-on count; memory answers in the same cycle.
// Notes:   Received stream words are gathered by a monitor into a queue.
`timescale 1ns/1ns
module sipa_isp_port_tb;
   import sipa_pkg::*;
   localparam int POR_SIM = 20;
   logic i_clock, i_arst_n, i_wr_ready, sck, ss_n, mosi, rst_n, o_miso, o_miso_oe;
   logic o_io_release, o_por_done, o_mode, o_wr_valid, o_cmd_done, o_reload_error;
   logic o_overrun;
   logic [PAGE_W-1:0]   o_rd_page, o_cmd_page;
   logic [OFFSET_W-1:0] o_rd_offset;
   logic [7:0]          i_rd_data, o_cmd_opcode;
   logic [STREAM_W-1:0] o_wr_word;
   logic [STREAM_W-1:0] got[$];
   logic [7:0]          tx[$], rx[$];
   int                  err_count = 0, n_tests = 0, n_done = 0;

   sipa_isp_port #(.POR_COUNT(POR_SIM)) u_dut (.i_clock(i_clock), .i_arst_n(i_arst_n),
      .i_rst_pin_n(rst_n), .i_sck(sck), .i_ss_n(ss_n), .i_mosi(mosi), .o_miso(o_miso),
      .o_miso_oe(o_miso_oe), .o_io_release(o_io_release), .o_por_done(o_por_done),
      .o_in_system_programming_mode(o_mode), .o_rd_page(o_rd_page),
      .o_rd_offset(o_rd_offset), .i_rd_data(i_rd_data), .o_wr_valid(o_wr_valid),
      .i_wr_ready(i_wr_ready), .o_wr_word(o_wr_word), .o_cmd_done(o_cmd_done),
      .o_cmd_opcode(o_cmd_opcode), .o_cmd_page(o_cmd_page),
      .o_reload_error(o_reload_error), .o_overrun(o_overrun));
   sipa_prog_model u_prog (.o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi), .o_rst_n(rst_n),
      .i_miso(o_miso));

   // Code memory contents as a function of address
   function automatic logic [7:0] mem_at(input logic [5:0] pg, input logic [4:0] off);
      mem_at = {pg, 2'b11} ^ {3'b000, off};
   endfunction : mem_at
   assign i_rd_data = mem_at(o_rd_page, o_rd_offset);

   // Clock
   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   // Stream and completion monitor
   always @(posedge i_clock) begin
      if (o_wr_valid === 1'b1 && i_wr_ready === 1'b1) got.push_back(o_wr_word);
      if (o_cmd_done === 1'b1) n_done++;
   end

   task automatic chk_bit(input logic act, input logic exp, input string what);
      n_tests++;
      if (act !== exp) begin
         err_count++;
         $display("ERROR %0t bit %s", $time, what);
      end
   endtask : chk_bit

   task automatic chk_vec(input logic [31:0] act, input logic [31:0] exp, input string what);
      n_tests++;
      if (act !== exp) begin
         err_count++;
         $display("ERROR %0t %s got %0h want %0h", $time, what, act, exp);
      end
   endtask : chk_vec

   // Send one command with n data bytes 30h, 31h, ...
   task automatic run_cmd(input logic [7:0] pre1, input logic [7:0] op, input logic [5:0] pg,
                          input logic [4:0] off, input int n);
      logic [15:0] a;
      a  = {5'h15, pg, off};
      tx = {8'hAA, pre1, op, a[15:8], a[7:0]};
      for (int k = 0; k < n; k++) tx.push_back(8'h30 + 8'(k));
      got    = {};
      n_done = 0;
      u_prog.frame(tx, rx);
      repeat (20) @(negedge i_clock);
   endtask : run_cmd

   task automatic t_por();
      repeat (POR_SIM - 2) @(negedge i_clock);
      chk_bit(o_por_done, 1'b0, "por early");
      chk_bit(o_io_release, 1'b1, "io in por");
      repeat (5) @(negedge i_clock);
      chk_bit(o_por_done, 1'b1, "por done");
      chk_bit(o_io_release, 1'b0, "io running");
   endtask : t_por

   task automatic t_outside();
      #10000;
      run_cmd(8'h55, 8'h50, 6'h02, 5'h00, 2);
      chk_vec(got.size(), 0, "words outside");
      chk_vec(n_done, 0, "done outside");
      chk_bit(o_miso_oe, 1'b0, "oe outside");
   endtask : t_outside

   task automatic t_entry();
      u_prog.enter();
      chk_bit(o_io_release, 1'b1, "io release");
      chk_bit(o_mode, 1'b1, "mode entry");
   endtask : t_entry

   task automatic t_wrap();
      i_wr_ready = 1'b1;
      run_cmd(8'h55, 8'h50, 6'h2B, 5'h1E, 33);
      chk_vec(got.size(), 33, "word count");
      for (int k = 0; k < 33 && k < got.size(); k++)
         chk_vec(32'(got[k]), 32'({8'h50, 6'h2B, 5'(30 + k), 8'(8'h30 + k)}), "word");
      chk_bit(o_reload_error, 1'b1, "reload");
      chk_vec(n_done, 1, "done count");
      chk_vec({o_cmd_opcode, o_cmd_page}, {8'h50, 6'h2B}, "cmd info");
   endtask : t_wrap

   task automatic t_read();
      run_cmd(8'h55, 8'h30, 6'h11, 5'h1F, 3);
      for (int k = 0; k < 3; k++)
         chk_vec(rx[5 + k], mem_at(6'h11, 5'(31 + k)), "read byte");
      chk_bit(o_reload_error, 1'b0, "reload clear");
   endtask : t_read

   task automatic t_badpre();
      run_cmd(8'h54, 8'h50, 6'h05, 5'h03, 2);
      chk_vec(got.size(), 0, "bad preamble words");
      chk_vec(n_done, 0, "bad preamble done");
      // Wrong first preamble byte
      tx     = {8'hA5, 8'h55, 8'h50, 8'h00, 8'h00, 8'h30};
      got    = {};
      n_done = 0;
      u_prog.frame(tx, rx);
      repeat (20) @(negedge i_clock);
      chk_vec(got.size(), 0, "bad first byte words");
      chk_vec(n_done, 0, "bad first byte done");
   endtask : t_badpre

   task automatic t_stall();
      i_wr_ready = 1'b0;
      run_cmd(8'h55, 8'h51, 6'h01, 5'h00, 4);
      chk_bit(o_wr_valid, 1'b1, "valid held");
      chk_bit(o_overrun, 1'b1, "overrun");
      chk_vec(got.size(), 0, "no take in stall");
      i_wr_ready = 1'b1;
      repeat (10) @(negedge i_clock);
      chk_vec(got.size(), 3, "drained count");
      chk_vec(32'(got[0]), 32'({8'h51, 6'h01, 5'h00, 8'h30}), "first kept");
      chk_vec(32'(got[1]), 32'({8'h51, 6'h01, 5'h01, 8'h31}), "second kept");
      chk_vec(32'(got[2]), 32'({8'h51, 6'h01, 5'h03, 8'h33}), "last kept");
      chk_bit(o_wr_valid, 1'b0, "drained empty");
   endtask : t_stall

   task automatic t_exit();
      u_prog.leave();
      repeat (10) @(negedge i_clock);
      chk_bit(o_mode, 1'b0, "mode exit");
      chk_bit(o_miso_oe, 1'b0, "oe exit");
      chk_bit(o_io_release, 1'b0, "io back");
   endtask : t_exit

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   // Watchdog
   initial begin
      #500000;
      err_count++;
      end_sim();
   end

   // Main sequence
   initial begin
      i_arst_n   = 1'b0;
      i_wr_ready = 1'b0;
      repeat (3) @(negedge i_clock);
      i_arst_n = 1'b1;
      t_por();
      t_outside();
      t_entry();
      t_wrap();
      t_read();
      t_badpre();
      t_stall();
      t_exit();
      end_sim();
   end
endmodule : sipa_isp_port_tb
